// ### scs_top.sv
// System clock source select: direct, prescaler, PLL and wakeup paths
`timescale 1ns/1ps
module scs_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Input clock pins
    input wire logic crystal_input_pin,
    input wire logic external_clock_pin,
    input wire logic internal_clock_src,
    input wire logic wakeup_clock,
    // Configuration
    input wire scs_pkg::scs_cfg_t cfg,
    // Generated clock and status
    output logic system_clock,
    output scs_pkg::scs_status_t status
);
    import scs_pkg::*;

    logic [SCS_PINS-1:0] pins;
    logic [SCS_PINS-1:0] s1_q;
    logic [SCS_PINS-1:0] s2_q;
    logic [SCS_PINS-1:0] s3_q;
    logic [SCS_PINS-1:0] lvl_q;
    logic [SCS_PINS-1:0] lvl_d;
    logic [SCS_PINS-1:0] rise_q;
    scs_mode_t mode_q;
    scs_mode_t mode_d;
    logic ref_lvl;
    logic ref_rise;
    logic [SCS_PRE_W:0] pre_k;
    logic [SCS_P_W:0] pll_p;
    logic [SCS_N_W:0] pll_n;
    logic [SCS_K2_W:0] pll_k2;
    logic [SCS_N_W:0] mult_q;
    logic [SCS_CREDIT_W-1:0] credit_q;
    logic [SCS_CREDIT_W-1:0] credit_add;
    logic [SCS_CREDIT_W-1:0] credit_sub;
    logic vco_tick;
    logic pre_out;
    logic pll_out;
    logic pll_mode;

    assign pins = {wakeup_clock, internal_clock_src, external_clock_pin, crystal_input_pin};

    // ------------------------------------------------------------
    // Pin synchronisers with agreement filter
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else
        begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign lvl_d = (s2_q & ~(s2_q ^ s3_q)) | (lvl_q & (s2_q ^ s3_q));

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lvl_q <= '0;
            rise_q <= '0;
        end
        else
        begin
            lvl_q <= lvl_d;
            rise_q <= lvl_d & ~lvl_q;
        end
    end

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    always_comb
    begin
        case (cfg.clock_source_select)
            SCS_SEL_DIRECT: mode_d = SCS_MODE_DIRECT;
            SCS_SEL_PLL: mode_d = cfg.vco_bypass ? SCS_MODE_PRESCALE : SCS_MODE_PLL;
            SCS_SEL_WAKEUP: mode_d = SCS_MODE_WAKEUP;
            default: mode_d = SCS_MODE_WAKEUP;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            mode_q <= SCS_MODE_WAKEUP;
        else
            mode_q <= mode_d;
    end

    assign pll_mode = (mode_q == SCS_MODE_PLL);

    // Oscillator or on-chip source feeds prescaler and PLL
    assign ref_lvl = cfg.clock_source_internal ? lvl_q[SCS_PIN_INT] : lvl_q[SCS_PIN_OSC];
    assign ref_rise = cfg.clock_source_internal ? rise_q[SCS_PIN_INT] : rise_q[SCS_PIN_OSC];

    // Factors are field plus one
    assign pre_k = {1'b0, cfg.prescaler_divider_field} + 1'b1;
    assign pll_p = {1'b0, cfg.pll_input_divider_field} + 1'b1;
    assign pll_n = {1'b0, cfg.pll_feedback_multiplier_field} + 1'b1;
    assign pll_k2 = {1'b0, cfg.pll_output_divider_field} + 1'b1;

    // ------------------------------------------------------------
    // Prescaler path
    // ------------------------------------------------------------
    scs_divider #(.W(SCS_PRE_W)) u_prescaler (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .src_level(ref_lvl),
        .src_rise(ref_rise),
        .div_k(pre_k),
        .div_out(pre_out)
    );

    // ------------------------------------------------------------
    // PLL: slewed multiplier and credit based VCO
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            mult_q <= SCS_MULT_RESET;
        else if (!pll_mode)
            mult_q <= SCS_MULT_RESET;
        else if (ref_rise && mult_q < pll_n)
            mult_q <= mult_q + 1'b1;
        else if (ref_rise && mult_q > pll_n)
            mult_q <= mult_q - 1'b1;
    end

    // Each reference edge credits the slewed multiplier mult_q unless credit_q has its top bit set, each VCO tick spends P
    assign vco_tick = pll_mode && (credit_q >= SCS_CREDIT_W'(pll_p));
    assign credit_add = (ref_rise && !credit_q[SCS_CREDIT_W-1]) ? SCS_CREDIT_W'(mult_q) : '0;
    assign credit_sub = vco_tick ? SCS_CREDIT_W'(pll_p) : '0;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            credit_q <= '0;
        else if (!pll_mode)
            credit_q <= '0;
        else
            credit_q <= credit_q + credit_add - credit_sub;
    end

    scs_divider #(.W(SCS_K2_W)) u_k2 (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .src_level(vco_tick),
        .src_rise(vco_tick),
        .div_k(pll_k2),
        .div_out(pll_out)
    );

    // ------------------------------------------------------------
    // Output clock mux
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            system_clock <= 1'b0;
        else
        begin
            case (mode_q)
                SCS_MODE_DIRECT: system_clock <= lvl_q[SCS_PIN_EXT];
                SCS_MODE_PRESCALE: system_clock <= pre_out;
                SCS_MODE_PLL: system_clock <= pll_out;
                SCS_MODE_WAKEUP: system_clock <= lvl_q[SCS_PIN_WU];
                default: system_clock <= lvl_q[SCS_PIN_WU];
            endcase
        end
    end

    // ------------------------------------------------------------
    // Status
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            status <= '0;
        else
        begin
            status.mode <= mode_q;
            status.pll_locked <= pll_mode && (mult_q == pll_n);
            status.band_error <= (cfg.vco_band_select == SCS_BAND_BAD);
            case (cfg.vco_band_select)
                SCS_BAND_LOW: status.vco_band_active <= SCS_BAND_LOW;
                SCS_BAND_MID: status.vco_band_active <= SCS_BAND_MID;
                SCS_BAND_HIGH: status.vco_band_active <= SCS_BAND_HIGH;
                default: status.vco_band_active <= status.vco_band_active;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_direct;
        @(posedge sys_clk) disable iff (!rst_n)
        (mode_q == SCS_MODE_DIRECT) |=> (system_clock == $past(lvl_q[SCS_PIN_EXT]));
    endproperty
    a_direct: assert property (p_direct) else $error("direct drive not followed");

    property p_prescale_sel;
        @(posedge sys_clk) disable iff (!rst_n)
        (cfg.clock_source_select == SCS_SEL_PLL && cfg.vco_bypass) |=> (mode_q == SCS_MODE_PRESCALE);
    endproperty
    a_prescale_sel: assert property (p_prescale_sel) else $error("prescale mode missed");

    property p_pre_range;
        @(posedge sys_clk) disable iff (!rst_n)
        (mode_q == SCS_MODE_PRESCALE && pre_k == SCS_PRE_MAX_DIV && $stable(mode_q)
            && $stable(pre_k) && !$past(ref_rise)) |=> $stable(system_clock);
    endproperty
    a_pre_range: assert property (p_pre_range) else $error("max prescale moved off edge");

    property p_bypass_one;
        @(posedge sys_clk) disable iff (!rst_n)
        (mode_q == SCS_MODE_PRESCALE && pre_k == 1 && !cfg.clock_source_internal)
            ##1 $stable(mode_q) |=> (system_clock == $past(lvl_q[SCS_PIN_OSC], 2));
    endproperty
    a_bypass_one: assert property (p_bypass_one) else $error("bypass by one not direct");

    property p_pll_out;
        @(posedge sys_clk) disable iff (!rst_n)
        pll_mode |=> (system_clock == $past(pll_out));
    endproperty
    a_pll_out: assert property (p_pll_out) else $error("pll output not selected");

    property p_credit;
        @(posedge sys_clk) disable iff (!rst_n)
        vco_tick |-> (credit_q >= SCS_CREDIT_W'(pll_p)) && (mode_q == SCS_MODE_PLL);
    endproperty
    a_credit: assert property (p_credit) else $error("vco tick without credit");

    property p_slew;
        @(posedge sys_clk) disable iff (!rst_n)
        (pll_mode && $past(pll_mode)) |-> (mult_q <= $past(mult_q) + 1) && (mult_q + 1 >= $past(mult_q));
    endproperty
    a_slew: assert property (p_slew) else $error("pll multiplier jumped");

    property p_k2_edge;
        @(posedge sys_clk) disable iff (!rst_n)
        (pll_mode && pll_k2 > 1 && !vco_tick && $stable(pll_k2)) |=> $stable(pll_out);
    endproperty
    a_k2_edge: assert property (p_k2_edge) else $error("k2 output moved without vco tick");

    property p_band;
        @(posedge sys_clk) disable iff (!rst_n)
        (cfg.vco_band_select != SCS_BAND_BAD) |=>
            (status.vco_band_active == $past(cfg.vco_band_select)) && !status.band_error;
    endproperty
    a_band: assert property (p_band) else $error("vco band not applied");

    property p_wakeup;
        @(posedge sys_clk) disable iff (!rst_n)
        (mode_q == SCS_MODE_WAKEUP) |=> (system_clock == $past(lvl_q[SCS_PIN_WU]));
    endproperty
    a_wakeup: assert property (p_wakeup) else $error("wakeup source not followed");
endmodule

// ### scs_pkg.sv
// Constants, types and encodings for the system clock source select block
//
// Overview of operation
// - Source select 11 drives the system clock straight from the external clock pin.
// - Source select 10 with vco bypass 1 divides the oscillator or internal source by prescaler+1.
// - A prescale factor of one passes the source clock with its own high and low times.
// - The largest prescaler setting divides the source by 1024.
// - Bypass from the crystal input with factor one behaves like direct drive.
// - Source select 10 with vco bypass 0 enables the PLL and uses its output.
// - The PLL factor is N/(P*K2), each being its programmed field plus one.
// - The PLL reference is selectable between the crystal input and the on-chip source.
// - The PLL multiplier approaches N gradually, one step per reference edge; P and K2 take effect at once.
// - The system clock is the VCO output divided by K2, K2 VCO cycles per system cycle.
// - The two-bit VCO band field selects low, middle or high band with 00, 01 and 10.
// - Source select 00 runs the system clock from the low-frequency wakeup source.
package scs_pkg;

    // ------------------------------------------------------------
    // Field widths
    // ------------------------------------------------------------
    localparam int SCS_PRE_W = 10;
    localparam int SCS_P_W = 4;
    localparam int SCS_N_W = 8;
    localparam int SCS_K2_W = 7;
    localparam int SCS_CREDIT_W = 16;
    localparam int SCS_PINS = 4;

    // ------------------------------------------------------------
    // Input clock pin positions in the synchroniser vector
    // ------------------------------------------------------------
    localparam int SCS_PIN_OSC = 0;
    localparam int SCS_PIN_EXT = 1;
    localparam int SCS_PIN_INT = 2;
    localparam int SCS_PIN_WU = 3;

    // ------------------------------------------------------------
    // Source select and band codes
    // ------------------------------------------------------------
    localparam logic [1:0] SCS_SEL_WAKEUP = 2'h0;
    localparam logic [1:0] SCS_SEL_RSVD = 2'h1;
    localparam logic [1:0] SCS_SEL_PLL = 2'h2;
    localparam logic [1:0] SCS_SEL_DIRECT = 2'h3;
    localparam logic [1:0] SCS_BAND_LOW = 2'h0;
    localparam logic [1:0] SCS_BAND_MID = 2'h1;
    localparam logic [1:0] SCS_BAND_HIGH = 2'h2;
    localparam logic [1:0] SCS_BAND_BAD = 2'h3;

    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [SCS_N_W:0] SCS_MULT_RESET = 9'h001;
    localparam int SCS_PRE_MAX_DIV = 1024;

    typedef enum logic [2:0] {
        SCS_MODE_WAKEUP = 3'b000,
        SCS_MODE_DIRECT = 3'b001,
        SCS_MODE_PRESCALE = 3'b010,
        SCS_MODE_PLL = 3'b011
    } scs_mode_t;

    typedef struct packed {
        logic [1:0] clock_source_select;
        logic vco_bypass;
        logic clock_source_internal;
        logic [SCS_PRE_W-1:0] prescaler_divider_field;
        logic [SCS_P_W-1:0] pll_input_divider_field;
        logic [SCS_N_W-1:0] pll_feedback_multiplier_field;
        logic [SCS_K2_W-1:0] pll_output_divider_field;
        logic [1:0] vco_band_select;
    } scs_cfg_t;

    typedef struct packed {
        logic pll_locked;
        logic band_error;
        logic [1:0] vco_band_active;
        logic [2:0] mode;
    } scs_status_t;

endpackage

// ### scs_divider.sv
// Integer divider of a sampled clock stream
`timescale 1ns/1ps
module scs_divider #(
    parameter int W = 10
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Source stream
    input wire logic src_level,
    input wire logic src_rise,
    input wire logic [W:0] div_k,
    // Divided output
    output logic div_out
);
    logic [W:0] cnt_q;
    logic [W:0] cnt_d;
    logic [W:0] k_last;

    assign k_last = div_k - {{W{1'b0}}, 1'b1};
    assign cnt_d = (cnt_q >= k_last) ? '0 : cnt_q + {{W{1'b0}}, 1'b1};

    // ------------------------------------------------------------
    // Period counter
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q <= '0;
        else if (src_rise)
            cnt_q <= cnt_d;
    end

    // High for the first div_k/2 source periods, rounded down, of each output period
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            div_out <= 1'b0;
        else if (div_k <= {{W{1'b0}}, 1'b1})
            div_out <= src_level;
        else if (src_rise)
            div_out <= (cnt_d < (div_k >> 1));
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_wrap;
        @(posedge sys_clk) disable iff (!rst_n)
        (src_rise && div_k > 1 && cnt_q == k_last && $stable(div_k)) |=> (cnt_q == '0);
    endproperty
    a_wrap: assert property (p_wrap) else $error("divider did not wrap after K");

    property p_follow;
        @(posedge sys_clk) disable iff (!rst_n)
        (div_k == 1) |=> (div_out == $past(src_level));
    endproperty
    a_follow: assert property (p_follow) else $error("factor one does not follow");

    property p_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        (!src_rise && div_k > 1 && $stable(div_k)) |=> $stable(div_out);
    endproperty
    a_hold: assert property (p_hold) else $error("divider output moved without edge");
endmodule

// ### tb_scs_top.sv
// Self-checking testbench for the system clock source select block
`timescale 1ns/1ps
module tb_scs_top;
    import scs_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic sys_clk;
    logic rst_n;
    logic crystal_input_pin;
    logic external_clock_pin;
    logic internal_clock_src;
    logic wakeup_clock;
    scs_cfg_t cfg;
    logic system_clock;
    scs_status_t status;
    int err_total = 0;
    int cmp_count = 0;
    int tcnt = 0;

    scs_top dut (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .crystal_input_pin(crystal_input_pin),
        .external_clock_pin(external_clock_pin),
        .internal_clock_src(internal_clock_src),
        .wakeup_clock(wakeup_clock),
        .cfg(cfg),
        .system_clock(system_clock),
        .status(status)
    );

    // ------------------------------------------------------------
    // Clock and source clocks: periods 8, 6, 10 and 12 cycles
    // ------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    always @(negedge sys_clk) tcnt <= tcnt + 1;
    assign crystal_input_pin = ((tcnt / 4) % 2) == 1;
    assign external_clock_pin = ((tcnt / 3) % 2) == 1;
    assign internal_clock_src = ((tcnt / 5) % 2) == 1;
    assign wakeup_clock = ((tcnt / 6) % 2) == 1;

    // ------------------------------------------------------------
    // Compare and report
    // ------------------------------------------------------------
    task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic check_int(input string what, input int exp, input int got);
        cmp_count++;
        if (got != exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Period measurement of the generated clock
    // ------------------------------------------------------------
    task automatic measure(input int nper, output int span, output int high);
        int w;
        int rises;
        logic prev;
        w = 0;
        while (system_clock !== 1'b0 && w < 20000)
        begin
            @(negedge sys_clk);
            w++;
        end
        while (system_clock !== 1'b1 && w < 20000)
        begin
            @(negedge sys_clk);
            w++;
        end
        if (w >= 20000)
            check_int("rise wait", 0, w);
        span = 0;
        high = 1;
        rises = 0;
        prev = 1'b1;
        while (rises < nper && span < 40000)
        begin
            @(negedge sys_clk);
            span++;
            if (prev === 1'b0 && system_clock === 1'b1)
                rises++;
            if (rises == 0 && system_clock === 1'b1)
                high++;
            prev = system_clock;
        end
    endtask

    // Applies one configuration and checks period, high time and mode
    task automatic run_case(input logic [1:0] sel, input logic byp, input logic isrc,
                            input int pre, input int p, input int n, input int k2,
                            input int nper, input int per, input int hi,
                            input logic [2:0] exp_mode);
        int w;
        int span;
        int high;
        int refp;
        cfg.clock_source_select = sel;
        cfg.vco_bypass = byp;
        cfg.clock_source_internal = isrc;
        cfg.prescaler_divider_field = SCS_PRE_W'(pre - 1);
        cfg.pll_input_divider_field = SCS_P_W'(p - 1);
        cfg.pll_feedback_multiplier_field = SCS_N_W'(n - 1);
        cfg.pll_output_divider_field = SCS_K2_W'(k2 - 1);
        refp = isrc ? 10 : 8;
        w = 0;
        if (exp_mode == SCS_MODE_PLL)
        begin
            repeat (3) @(negedge sys_clk);
            check_val("lock early", 16'h0, {15'h0, status.pll_locked});
            w = 3;
            while (status.pll_locked !== 1'b1 && w < 2000)
            begin
                @(negedge sys_clk);
                w++;
            end
            check_int("slew span", 1, int'(w > (n - 2) * refp && w <= n * refp));
            repeat (4 * refp) @(negedge sys_clk);
        end
        else
            repeat (48) @(negedge sys_clk);
        measure(nper, span, high);
        check_int("period span", nper * per, span);
        if (hi >= 0)
            check_int("high time", hi, high);
        check_val("mode", {13'h0, exp_mode}, {13'h0, status.mode});
        $display("Case sel %0d pre %0d pll %0d/%0d/%0d done", sel, pre, p, n, k2);
    endtask

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    initial
    begin
        #(60000 * 50);
        err_total++;
        $display("MISMATCH watchdog expected done seen hang");
        print_verdict();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst_n = 1'b0;
        cfg = '0;
        cfg.clock_source_select = SCS_SEL_DIRECT;
        repeat (6) @(negedge sys_clk);
        check_val("reset clock", 16'h0, {15'h0, system_clock});
        check_val("reset status", 16'h0, {9'h0, status});
        rst_n = 1'b1;
        $display("Reset test done");
        for (int b = 0; b < 3; b++)
        begin
            cfg.vco_band_select = 2'(b);
            repeat (3) @(negedge sys_clk);
            check_val("band", 16'(b), {14'h0, status.vco_band_active});
            check_val("band error", 16'h0, {15'h0, status.band_error});
        end
        cfg.vco_band_select = SCS_BAND_BAD;
        repeat (3) @(negedge sys_clk);
        check_val("band kept", 16'h2, {14'h0, status.vco_band_active});
        check_val("band error", 16'h1, {15'h0, status.band_error});
        $display("Band test done");
        run_case(SCS_SEL_DIRECT, 1'b0, 1'b0, 1, 1, 1, 1, 4, 6, 3, SCS_MODE_DIRECT);
        run_case(SCS_SEL_WAKEUP, 1'b0, 1'b0, 1, 1, 1, 1, 4, 12, 6, SCS_MODE_WAKEUP);
        run_case(SCS_SEL_RSVD, 1'b0, 1'b0, 1, 1, 1, 1, 4, 12, 6, SCS_MODE_WAKEUP);
        run_case(SCS_SEL_PLL, 1'b1, 1'b0, 1, 1, 1, 1, 4, 8, 4, SCS_MODE_PRESCALE);
        run_case(SCS_SEL_PLL, 1'b1, 1'b0, 2, 1, 1, 1, 4, 16, 8, SCS_MODE_PRESCALE);
        run_case(SCS_SEL_PLL, 1'b1, 1'b0, 3, 1, 1, 1, 4, 24, 8, SCS_MODE_PRESCALE);
        run_case(SCS_SEL_PLL, 1'b1, 1'b1, 2, 1, 1, 1, 4, 20, 10, SCS_MODE_PRESCALE);
        run_case(SCS_SEL_PLL, 1'b0, 1'b0, 1, 2, 4, 2, 10, 8, -1, SCS_MODE_PLL);
        run_case(SCS_SEL_PLL, 1'b1, 1'b0, 1024, 1, 1, 1, 1, 8192, 4096, SCS_MODE_PRESCALE);
        run_case(SCS_SEL_PLL, 1'b0, 1'b0, 1, 1, 8, 2, 10, 2, -1, SCS_MODE_PLL);
        run_case(SCS_SEL_DIRECT, 1'b0, 1'b0, 1, 1, 1, 1, 4, 6, 3, SCS_MODE_DIRECT);
        run_case(SCS_SEL_PLL, 1'b0, 1'b1, 1, 1, 5, 5, 10, 10, -1, SCS_MODE_PLL);
        print_verdict();
    end
endmodule
